//--- rtl/lane_link_monitor_regs.sv
// Per-lane status, diagnostic counters and phase-adjust registers of a serial converter link
`timescale 1ns/1ps

// Contract
// - Every register of the group except the test mode and error report words exists once per lane and keeps that lane's values apart.
// - Bit 16 of the alignment-configuration word is the Subclass 2 adjust direction, reset 0.
// - Bit 8 of the same word is the Subclass 2 phase-adjust request, reset 0.
// - Bits 3:0 of the same word hold the Subclass 2 adjust step count, reset 0x0.
// - A receiver holds fields captured from the lane; a transmitter sends programmed fields.
// - In test mode 001 the test error count rises for each received character not K28.5.
// - In test mode 010 the test error count rises for each unexpected received character.
// - The test error count clears on entering an active test mode and holds on leaving it.
// - While enabled, the link error count rises by one in each cycle with a disparity or not-in-table error.
// - Turning the error count enable off and on again resets the link error count.
// - In test mode 010 a counter counts whole alignment sequences, cleared on entry, held after.
// - In test mode 010 a counter counts alignment multiframes, cleared on entry, held after.
// - Bits 9:0 of a read-only register report the lane's receive buffer fill level.
// - The management register port and the lane events are both sampled on the one clock clk_sys.
module lane_link_monitor_regs #(
   parameter int            NUM_LANES = 2,
   parameter int            FILL_W    = 10,
   parameter bit            IS_RX     = 1'b1
) (
   // Clock and reset
   input  wire logic                                  clk_sys,
   input  wire logic                                  srst,
   // Management register port
   input  wire logic                                  reg_wr,
   input  wire logic                                  reg_rd,
   input  wire logic [11:0]                           reg_addr,
   input  wire logic [31:0]                           reg_wdata,
   output logic      [31:0]                           reg_rdata,
   output logic                                       reg_rvalid,
   // Lane receive events and status
   input  wire lane_mon_pkg::lane_event_s [NUM_LANES-1:0]   lane_event,
   input  wire logic  [NUM_LANES-1:0][FILL_W-1:0]           lane_buf_fill,
   input  wire logic  [NUM_LANES-1:0]                        ila_cfg_capture,
   input  wire lane_mon_pkg::phase_adjust_s [NUM_LANES-1:0] ila_cfg_rx,
   // Fields sent in the alignment sequence, and controls to the lanes
   output lane_mon_pkg::phase_adjust_s [NUM_LANES-1:0]      ila_cfg_tx,
   output logic      [2:0]                                   test_mode,
   output logic                                              err_cnt_en
);

   // ==========================================================================
   // Helpers
   // ==========================================================================
   // Next value of a counter: a clear still keeps an event of the same cycle
   function automatic logic [31:0] cnt_next(input logic [31:0] cnt,
                                            input logic        inc,
                                            input logic        clr);
      logic [31:0] base;
      base = clr ? lane_mon_pkg::RST_COUNT : cnt;
      return base + {31'h0000_0000, inc};
   endfunction

   // Packs the phase-adjust fields into their register word, other bits zero
   function automatic logic [31:0] pack_adj(input lane_mon_pkg::phase_adjust_s f);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[lane_mon_pkg::POS_ADJ_DIR] = f.direction;
      w[lane_mon_pkg::POS_ADJ_REQ] = f.request;
      w[lane_mon_pkg::POS_ADJ_CNT +: lane_mon_pkg::ADJ_CNT_W] = f.step_count;
      return w;
   endfunction

   // ==========================================================================
   // Per-lane storage and address decode
   // ==========================================================================
   lane_mon_pkg::phase_adjust_s [NUM_LANES-1:0] phase_adj;
   logic [NUM_LANES-1:0][31:0]  test_err_cnt;
   logic [NUM_LANES-1:0][31:0]  link_err_cnt;
   logic [NUM_LANES-1:0][31:0]  ila_cnt;
   logic [NUM_LANES-1:0][31:0]  mf_cnt;
   logic [NUM_LANES-1:0][FILL_W-1:0] buf_fill;
   logic [2:0]                  prev_mode;
   logic                        prev_err_en;
   logic                        lane_hit;
   logic [4:0]                  lane_sel;
   logic [5:0]                  lane_ofs;
   logic                        enter_active;
   logic                        enter_ila;
   logic                        err_reenable;

   // Lane window decode
   assign lane_hit = reg_addr[11] && (int'(reg_addr[10:6]) < NUM_LANES);
   assign lane_sel = reg_addr[10:6];
   assign lane_ofs = reg_addr[5:0];

   // Mode entry and enable re-arm detection
   assign enter_active = (test_mode != prev_mode) &&
                         (test_mode == lane_mon_pkg::MODE_CONT_COMMA ||
                          test_mode == lane_mon_pkg::MODE_CONT_ILA);
   assign enter_ila    = (test_mode != prev_mode) &&
                         (test_mode == lane_mon_pkg::MODE_CONT_ILA);
   assign err_reenable = err_cnt_en && !prev_err_en;

   // ==========================================================================
   // Global control registers
   // ==========================================================================
   // Test mode selector and error count enable, written by software
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         test_mode  <= lane_mon_pkg::RST_TEST_MODE;
         err_cnt_en <= lane_mon_pkg::RST_ERR_CNT_EN;
      end else if (reg_wr) begin
         if (reg_addr == lane_mon_pkg::ADDR_TEST_MODE) begin
            test_mode <= reg_wdata[lane_mon_pkg::TEST_MODE_W-1:0];
         end
         if (reg_addr == lane_mon_pkg::ADDR_ERR_REPORT) begin
            err_cnt_en <= reg_wdata[lane_mon_pkg::POS_ERR_CNT_EN];
         end
      end
   end

   // History of mode and enable for edge detection
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         prev_mode   <= lane_mon_pkg::RST_TEST_MODE;
         prev_err_en <= lane_mon_pkg::RST_ERR_CNT_EN;
      end else begin
         prev_mode   <= test_mode;
         prev_err_en <= err_cnt_en;
      end
   end

   // ==========================================================================
   // Per-lane logic
   // ==========================================================================
   for (genvar g = 0; g < NUM_LANES; g++) begin : g_lane
      lane_mon_pkg::lane_event_s ev;
      logic                      test_err_inc;
      logic                      wr_adj;
      assign ev     = lane_event[g];
      assign wr_adj = reg_wr && lane_hit && (int'(lane_sel) == g) &&
                      (lane_ofs == lane_mon_pkg::OFS_PHASE_ADJUST);

      // Character error per active test mode
      always_comb begin
         test_err_inc = 1'b0;
         if (ev.char_valid) begin
            if (test_mode == lane_mon_pkg::MODE_CONT_COMMA) begin
               test_err_inc = !(ev.char_is_k &&
                                ev.char_data == lane_mon_pkg::CHAR_K28_5);
            end else if (test_mode == lane_mon_pkg::MODE_CONT_ILA) begin
               test_err_inc = ev.char_unexpected;
            end
         end
      end

      // Phase-adjust fields: captured on receive, programmed on transmit
      always_ff @(posedge clk_sys) begin
         if (srst) begin
            phase_adj[g] <= lane_mon_pkg::RST_PHASE_ADJUST;
         end else if (IS_RX) begin
            if (ila_cfg_capture[g]) begin
               phase_adj[g] <= ila_cfg_rx[g];
            end
         end else if (wr_adj) begin
            phase_adj[g].direction  <= reg_wdata[lane_mon_pkg::POS_ADJ_DIR];
            phase_adj[g].request    <= reg_wdata[lane_mon_pkg::POS_ADJ_REQ];
            phase_adj[g].step_count <=
               reg_wdata[lane_mon_pkg::POS_ADJ_CNT +: lane_mon_pkg::ADJ_CNT_W];
         end
      end

      // Transmit copy of the fields toward the alignment sequence generator
      always_ff @(posedge clk_sys) begin
         if (srst) begin
            ila_cfg_tx[g] <= lane_mon_pkg::RST_PHASE_ADJUST;
         end else begin
            ila_cfg_tx[g] <= IS_RX ? lane_mon_pkg::RST_PHASE_ADJUST : phase_adj[g];
         end
      end

      // Test character error counter, held outside active modes
      always_ff @(posedge clk_sys) begin
         if (srst) begin
            test_err_cnt[g] <= lane_mon_pkg::RST_COUNT;
         end else if (enter_active || test_err_inc) begin
            test_err_cnt[g] <= cnt_next(test_err_cnt[g], test_err_inc, enter_active);
         end
      end

      // Link decode error counter, re-armed by the enable
      always_ff @(posedge clk_sys) begin
         if (srst) begin
            link_err_cnt[g] <= lane_mon_pkg::RST_COUNT;
         end else if (err_cnt_en) begin
            link_err_cnt[g] <= cnt_next(link_err_cnt[g],
                                        ev.disparity_err || ev.not_in_table_err,
                                        err_reenable);
         end
      end

      // Alignment sequence and multiframe counters in mode 010
      always_ff @(posedge clk_sys) begin
         if (srst) begin
            ila_cnt[g] <= lane_mon_pkg::RST_COUNT;
            mf_cnt[g]  <= lane_mon_pkg::RST_COUNT;
         end else if (test_mode == lane_mon_pkg::MODE_CONT_ILA) begin
            ila_cnt[g] <= cnt_next(ila_cnt[g], ev.ila_end, enter_ila);
            mf_cnt[g]  <= cnt_next(mf_cnt[g], ev.multiframe_end, enter_ila);
         end
      end

      // Buffer fill level sample
      always_ff @(posedge clk_sys) begin
         if (srst) begin
            buf_fill[g] <= '0;
         end else begin
            buf_fill[g] <= lane_buf_fill[g];
         end
      end
   end

   // ==========================================================================
   // Read path
   // ==========================================================================
   logic [31:0] next_rdata;

   // Read data mux, unmapped and reserved bits give zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (reg_addr == lane_mon_pkg::ADDR_TEST_MODE) begin
         next_rdata[lane_mon_pkg::TEST_MODE_W-1:0] = test_mode;
      end else if (reg_addr == lane_mon_pkg::ADDR_ERR_REPORT) begin
         next_rdata[lane_mon_pkg::POS_ERR_CNT_EN] = err_cnt_en;
      end else if (lane_hit) begin
         unique case (lane_ofs)
            lane_mon_pkg::OFS_PHASE_ADJUST:  next_rdata = pack_adj(phase_adj[lane_sel]);
            lane_mon_pkg::OFS_TEST_CHAR_ERR: next_rdata = test_err_cnt[lane_sel];
            lane_mon_pkg::OFS_DECODE_ERR:    next_rdata = link_err_cnt[lane_sel];
            lane_mon_pkg::OFS_TEST_ILA_CNT:  next_rdata = ila_cnt[lane_sel];
            lane_mon_pkg::OFS_TEST_MF_CNT:   next_rdata = mf_cnt[lane_sel];
            lane_mon_pkg::OFS_BUF_FILL:      next_rdata[FILL_W-1:0] = buf_fill[lane_sel];
            default:                         next_rdata = 32'h0000_0000;
         endcase
      end
   end

   // Registered read answer, one cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         reg_rdata  <= 32'h0000_0000;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         reg_rdata  <= reg_rd ? next_rdata : 32'h0000_0000;
      end
   end

   // ==========================================================================
   // Assertions on lane 0 and the read port
   // ==========================================================================
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   AST_COMMA_ERR_COUNT: assert property (
      (test_mode == lane_mon_pkg::MODE_CONT_COMMA && !enter_active &&
       lane_event[0].char_valid && !lane_event[0].char_is_k)
      |=> test_err_cnt[0] == $past(test_err_cnt[0]) + 32'h0000_0001)
      else $error("test error count missed a non comma character");

   AST_ILA_ERR_COUNT: assert property (
      (test_mode == lane_mon_pkg::MODE_CONT_ILA && !enter_active &&
       lane_event[0].char_valid && lane_event[0].char_unexpected)
      |=> test_err_cnt[0] == $past(test_err_cnt[0]) + 32'h0000_0001)
      else $error("test error count missed an unexpected character");

   AST_TEST_ERR_ENTRY: assert property (
      enter_active |=> test_err_cnt[0] <= 32'h0000_0001)
      else $error("test error count not cleared on mode entry");

   AST_TEST_ERR_HOLD: assert property (
      (test_mode != lane_mon_pkg::MODE_CONT_COMMA &&
       test_mode != lane_mon_pkg::MODE_CONT_ILA) [*2] |-> $stable(test_err_cnt[0]))
      else $error("test error count changed outside test mode");

   AST_LINK_ERR_COUNT: assert property (
      (err_cnt_en && !err_reenable && lane_event[0].disparity_err)
      |=> link_err_cnt[0] == $past(link_err_cnt[0]) + 32'h0000_0001)
      else $error("link error count missed a disparity error");

   AST_LINK_ERR_REARM: assert property (
      (!err_cnt_en ##1 err_cnt_en) |=> link_err_cnt[0] <= 32'h0000_0001)
      else $error("link error count not reset by re-enable");

   AST_ILA_SEQ_COUNT: assert property (
      (test_mode == lane_mon_pkg::MODE_CONT_ILA && !enter_ila && lane_event[0].ila_end)
      |=> ila_cnt[0] == $past(ila_cnt[0]) + 32'h0000_0001)
      else $error("alignment sequence count missed an event");

   AST_MF_ENTRY: assert property (
      enter_ila |=> mf_cnt[0] <= 32'h0000_0001)
      else $error("multiframe count not cleared on mode entry");

   AST_READ_LATENCY: assert property (
      reg_rd |=> reg_rvalid ##1 (!reg_rvalid || $past(reg_rd)))
      else $error("read answer not one cycle after strobe");

   AST_RESERVED_ZERO: assert property (
      (reg_rd && reg_addr == (lane_mon_pkg::LANE_BASE | 12'(lane_mon_pkg::OFS_PHASE_ADJUST)))
      |=> (reg_rdata & 32'hFFFE_FEF0) == 32'h0000_0000)
      else $error("reserved bits of phase adjust word not zero");

   AST_CAPTURE: assert property (
      (IS_RX && ila_cfg_capture[0]) |=> phase_adj[0] == $past(ila_cfg_rx[0]))
      else $error("received phase adjust fields not captured");

   // Hold, refusal, transmit, fill level and idle checks
   AST_LINK_ERR_HOLD: assert property (
      !err_cnt_en |=> $stable(link_err_cnt[0]))
      else $error("link error count moved while disabled");

   AST_ILA_SEQ_HOLD: assert property (
      test_mode != lane_mon_pkg::MODE_CONT_ILA |=> $stable(ila_cnt[0]))
      else $error("alignment sequence count moved outside mode 010");

   AST_RX_NO_WRITE: assert property (
      (IS_RX && !ila_cfg_capture[0]) |=> $stable(phase_adj[0]))
      else $error("received fields changed without capture");

   AST_TX_FIELDS: assert property (
      !IS_RX |=> ila_cfg_tx[0] == $past(phase_adj[0]))
      else $error("programmed fields not sent");

   AST_FILL_LEVEL: assert property (
      1'b1 |=> buf_fill[0] == $past(lane_buf_fill[0]))
      else $error("buffer fill level not tracked");

   AST_RDATA_IDLE: assert property (
      !reg_rd |=> !reg_rvalid && reg_rdata == 32'h0000_0000)
      else $error("read answer outside its one cycle");

   COV_COMMA_MODE: cover property (enter_active ##1 test_err_cnt[0] != 32'h0000_0000);
   COV_ILA_MODE:   cover property (enter_ila ##[1:20] mf_cnt[0] != 32'h0000_0000);
   COV_REARM:      cover property (!err_cnt_en ##1 err_cnt_en);
   COV_READ:       cover property (reg_rd ##1 reg_rvalid);

endmodule

//--- rtl/lane_mon_pkg.sv
// Package of offsets, field positions, reset values and carriers for the lane monitor registers
package lane_mon_pkg;

   // ==========================================================================
   // Register map, byte addresses
   // ==========================================================================
   localparam logic [11:0] ADDR_TEST_MODE       = 12'h000;
   localparam logic [11:0] ADDR_ERR_REPORT      = 12'h004;
   localparam logic [11:0] LANE_BASE            = 12'h800;
   localparam int          LANE_STRIDE_LSB      = 6;
   localparam logic [5:0]  OFS_PHASE_ADJUST     = 6'h1C;
   localparam logic [5:0]  OFS_TEST_CHAR_ERR    = 6'h20;
   localparam logic [5:0]  OFS_DECODE_ERR       = 6'h24;
   localparam logic [5:0]  OFS_TEST_ILA_CNT     = 6'h28;
   localparam logic [5:0]  OFS_TEST_MF_CNT      = 6'h2C;
   localparam logic [5:0]  OFS_BUF_FILL         = 6'h30;

   // ==========================================================================
   // Field positions and reset values
   // ==========================================================================
   localparam int          POS_ADJ_DIR          = 16;
   localparam int          POS_ADJ_REQ          = 8;
   localparam int          POS_ADJ_CNT          = 0;
   localparam int          ADJ_CNT_W            = 4;
   localparam int          TEST_MODE_W          = 3;
   localparam int          POS_ERR_CNT_EN       = 0;
   localparam logic [2:0]  RST_TEST_MODE        = 3'h0;
   localparam logic        RST_ERR_CNT_EN       = 1'b0;
   localparam logic [31:0] RST_COUNT            = 32'h0000_0000;

   // ==========================================================================
   // Test modes and characters
   // ==========================================================================
   localparam logic [2:0]  MODE_CONT_COMMA      = 3'h1;
   localparam logic [2:0]  MODE_CONT_ILA        = 3'h2;
   localparam logic [7:0]  CHAR_K28_5           = 8'hBC;

   // Subclass 2 phase-adjust fields of the alignment configuration
   typedef struct packed {
      logic                 direction;
      logic                 request;
      logic [3:0]           step_count;
   } phase_adjust_s;

   localparam phase_adjust_s RST_PHASE_ADJUST   = '{1'b0, 1'b0, 4'h0};

   // Per-lane events reported by the lane receive path
   typedef struct packed {
      logic                 char_valid;
      logic                 char_is_k;
      logic [7:0]           char_data;
      logic                 char_unexpected;
      logic                 ila_end;
      logic                 multiframe_end;
      logic                 disparity_err;
      logic                 not_in_table_err;
   } lane_event_s;

endpackage

//--- test/lane_rx_source.sv
// Behavioural model of the lane receive path that feeds the monitor registers
`timescale 1ns/1ps

module lane_rx_source #(
   parameter int NUM_LANES = 2,
   parameter int FILL_W    = 10
) (
   // Clock
   input  wire logic                                        clk_sys,
   // Lane events, status and captured alignment fields
   output lane_mon_pkg::lane_event_s   [NUM_LANES-1:0]      lane_event,
   output logic        [NUM_LANES-1:0][FILL_W-1:0]         lane_buf_fill,
   output logic        [NUM_LANES-1:0]                      ila_cfg_capture,
   output lane_mon_pkg::phase_adjust_s [NUM_LANES-1:0]      ila_cfg_rx
);
   // ==========================================================================
   // Idle state at time zero
   // ==========================================================================
   initial begin
      lane_event      = '0;
      lane_buf_fill   = '0;
      ila_cfg_capture = '0;
      ila_cfg_rx      = '0;
   end

   // Present one event word for n cycles, all changes on the falling edge
   task automatic send(input int g, input lane_mon_pkg::lane_event_s e, input int n);
      lane_mon_pkg::lane_event_s idle;
      idle           = '0;
      idle.char_data = ~e.char_data; // Stale data is not left on the bus
      repeat (n) @(negedge clk_sys) lane_event[g] = e;
      @(negedge clk_sys) lane_event[g] = idle;
   endtask

   // One capture pulse of received alignment fields on one lane
   task automatic capture(input int g, input lane_mon_pkg::phase_adjust_s v);
      @(negedge clk_sys);
      ila_cfg_rx[g]      = v;
      ila_cfg_capture[g] = 1'b1;
      @(negedge clk_sys);
      ila_cfg_capture[g] = 1'b0;
      ila_cfg_rx[g]      = ~v; // Fields no longer valid after the pulse
   endtask

   // Receive buffer fill level changes
   task automatic set_fill(input int g, input logic [FILL_W-1:0] v);
      @(negedge clk_sys) lane_buf_fill[g] = v;
   endtask
endmodule

//--- test/test_lane_link_monitor_regs.sv
// Self-checking testbench of the lane monitor register group
`timescale 1ns/1ps

`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_errors++; \
   $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end

module test_lane_link_monitor_regs;
   // ==========================================================================
   // Signals and events
   // ==========================================================================
   logic                                     clk_sys;
   logic                                     srst;
   logic                                     reg_wr;
   logic                                     reg_rd;
   logic [11:0]                              reg_addr;
   logic [31:0]                              reg_wdata;
   logic [31:0]                              reg_rdata;
   logic                                     reg_rvalid;
   lane_mon_pkg::lane_event_s   [1:0]        lane_event;
   logic [1:0][9:0]                          lane_buf_fill;
   logic [1:0]                               ila_cfg_capture;
   lane_mon_pkg::phase_adjust_s [1:0]        ila_cfg_rx;
   lane_mon_pkg::phase_adjust_s [1:0]        ila_cfg_tx;
   lane_mon_pkg::phase_adjust_s [1:0]        tx_cfg;
   logic [2:0]                               test_mode;
   logic                                     err_cnt_en;
   int                                       n_errors;
   int                                       n_compared;

   localparam lane_mon_pkg::lane_event_s EV_K285 = '{char_valid: 1'b1, char_is_k: 1'b1,
      char_data: lane_mon_pkg::CHAR_K28_5, default: '0};
   localparam lane_mon_pkg::lane_event_s EV_DBC = '{char_valid: 1'b1,
      char_data: lane_mon_pkg::CHAR_K28_5, default: '0};
   localparam lane_mon_pkg::lane_event_s EV_K1C = '{char_valid: 1'b1, char_is_k: 1'b1,
      char_data: 8'h1C, default: '0};
   localparam lane_mon_pkg::lane_event_s EV_BAD = '{char_valid: 1'b1, char_unexpected: 1'b1,
      default: '0};
   localparam lane_mon_pkg::lane_event_s EV_ILA = '{ila_end: 1'b1, default: '0};
   localparam lane_mon_pkg::lane_event_s EV_MF  = '{multiframe_end: 1'b1, default: '0};
   localparam lane_mon_pkg::lane_event_s EV_DSP = '{disparity_err: 1'b1, default: '0};
   localparam lane_mon_pkg::lane_event_s EV_NIT = '{not_in_table_err: 1'b1, default: '0};

   // Clock generation
   initial clk_sys = 1'b0;
   always #25 clk_sys = ~clk_sys;

   // ==========================================================================
   // Design and lane model
   // ==========================================================================
   lane_link_monitor_regs #(.NUM_LANES(2), .FILL_W(10), .IS_RX(1'b1)) dut (
      .clk_sys(clk_sys), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .lane_event(lane_event), .lane_buf_fill(lane_buf_fill),
      .ila_cfg_capture(ila_cfg_capture), .ila_cfg_rx(ila_cfg_rx),
      .ila_cfg_tx(ila_cfg_tx), .test_mode(test_mode), .err_cnt_en(err_cnt_en));

   lane_rx_source #(.NUM_LANES(2), .FILL_W(10)) src (
      .clk_sys(clk_sys), .lane_event(lane_event), .lane_buf_fill(lane_buf_fill),
      .ila_cfg_capture(ila_cfg_capture), .ila_cfg_rx(ila_cfg_rx));

   // Transmit build sharing the bus and lane model
   lane_link_monitor_regs #(.NUM_LANES(2), .FILL_W(10), .IS_RX(1'b0)) dut_tx (
      .clk_sys(clk_sys), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(), .reg_rvalid(),
      .lane_event(lane_event), .lane_buf_fill(lane_buf_fill),
      .ila_cfg_capture(ila_cfg_capture), .ila_cfg_rx(ila_cfg_rx),
      .ila_cfg_tx(tx_cfg), .test_mode(), .err_cnt_en());

   // ==========================================================================
   // Access tasks
   // ==========================================================================
   function automatic logic [11:0] la(input int g, input logic [5:0] o);
      return lane_mon_pkg::LANE_BASE + 12'(g << lane_mon_pkg::LANE_STRIDE_LSB) + {6'h00, o};
   endfunction

   task automatic results();
      $display("errors %0d, comparisons %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Single write strobe, one cycle
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(negedge clk_sys);
      reg_wr    = 1'b1;
      reg_addr  = a;
      reg_wdata = d;
      @(negedge clk_sys);
      reg_wr    = 1'b0;
   endtask

   // Read strobe, bounded wait for the answer, compare against expectation
   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      int i;
      @(negedge clk_sys);
      reg_rd   = 1'b1;
      reg_addr = a;
      @(negedge clk_sys);
      reg_rd   = 1'b0;
      for (i = 0; i < 4 && reg_rvalid !== 1'b1; i++) @(negedge clk_sys);
      if (i == 4) begin
         n_errors++;
         results();
      end
      `CHK(reg_rdata, exp)
   endtask

   // ==========================================================================
   // Main sequence
   // ==========================================================================
   initial begin
      n_errors = 0;
      n_compared = 0;
      {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      srst = 1'b1;
      repeat (2) @(negedge clk_sys);
      srst = 1'b0;
      // Reset values and an unmapped address
      rchk(la(0, lane_mon_pkg::OFS_PHASE_ADJUST), 32'h0000_0000);
      rchk(la(1, lane_mon_pkg::OFS_TEST_CHAR_ERR), 32'h0000_0000);
      rchk(12'h7F0, 32'h0000_0000);
      // Captured alignment fields, kept per lane, software writes refused
      src.capture(0, '{1'b1, 1'b1, 4'hF});
      src.capture(1, '{1'b0, 1'b0, 4'h5});
      wr(la(0, lane_mon_pkg::OFS_PHASE_ADJUST), 32'hFFFF_FFFA);
      rchk(la(0, lane_mon_pkg::OFS_PHASE_ADJUST), 32'h0001_010F);
      rchk(la(1, lane_mon_pkg::OFS_PHASE_ADJUST), 32'h0000_0005);
      `CHK(ila_cfg_tx, 12'h000)
      `CHK(tx_cfg, 12'h03A)
      // Buffer fill level, read-only
      src.set_fill(0, 10'h3FF);
      src.set_fill(1, 10'h155);
      wr(la(1, lane_mon_pkg::OFS_BUF_FILL), 32'hFFFF_FFFF);
      rchk(la(0, lane_mon_pkg::OFS_BUF_FILL), 32'h0000_03FF);
      rchk(la(1, lane_mon_pkg::OFS_BUF_FILL), 32'h0000_0155);
      // Continuous comma mode, reserved selector bits set
      wr(lane_mon_pkg::ADDR_TEST_MODE, 32'hFFFF_FFF9);
      rchk(lane_mon_pkg::ADDR_TEST_MODE, 32'h0000_0001);
      `CHK(test_mode, lane_mon_pkg::MODE_CONT_COMMA)
      src.send(0, EV_K285, 3);
      src.send(0, EV_DBC, 1);
      src.send(0, EV_K1C, 2);
      rchk(la(0, lane_mon_pkg::OFS_TEST_CHAR_ERR), 32'h0000_0003);
      rchk(la(1, lane_mon_pkg::OFS_TEST_CHAR_ERR), 32'h0000_0000);
      // Continuous alignment mode: entry clears, counts, then holds after exit
      wr(lane_mon_pkg::ADDR_TEST_MODE, 32'h0000_0002);
      rchk(la(0, lane_mon_pkg::OFS_TEST_CHAR_ERR), 32'h0000_0000);
      src.send(0, EV_BAD, 2);
      src.send(0, EV_K285, 2);
      src.send(1, EV_ILA, 2);
      src.send(1, EV_MF, 4);
      src.send(0, EV_ILA, 1);
      wr(lane_mon_pkg::ADDR_TEST_MODE, 32'h0000_0000);
      src.send(0, EV_BAD, 1);
      src.send(1, EV_ILA, 1);
      src.send(1, EV_MF, 1);
      rchk(la(0, lane_mon_pkg::OFS_TEST_CHAR_ERR), 32'h0000_0002);
      rchk(la(1, lane_mon_pkg::OFS_TEST_ILA_CNT), 32'h0000_0002);
      rchk(la(1, lane_mon_pkg::OFS_TEST_MF_CNT), 32'h0000_0004);
      rchk(la(0, lane_mon_pkg::OFS_TEST_ILA_CNT), 32'h0000_0001);
      // Link error counting, hold while disabled, clear on re-enable
      wr(lane_mon_pkg::ADDR_ERR_REPORT, 32'hFFFF_FFFF);
      rchk(lane_mon_pkg::ADDR_ERR_REPORT, 32'h0000_0001);
      `CHK(err_cnt_en, 1'b1)
      src.send(1, EV_DSP, 2);
      src.send(1, EV_NIT, 1);
      src.send(0, EV_DSP, 1);
      rchk(la(1, lane_mon_pkg::OFS_DECODE_ERR), 32'h0000_0003);
      rchk(la(0, lane_mon_pkg::OFS_DECODE_ERR), 32'h0000_0001);
      wr(lane_mon_pkg::ADDR_ERR_REPORT, 32'h0000_0000);
      src.send(1, EV_DSP, 1);
      rchk(la(1, lane_mon_pkg::OFS_DECODE_ERR), 32'h0000_0003);
      wr(lane_mon_pkg::ADDR_ERR_REPORT, 32'h0000_0001);
      rchk(la(1, lane_mon_pkg::OFS_DECODE_ERR), 32'h0000_0000);
      src.send(1, EV_NIT, 1);
      rchk(la(1, lane_mon_pkg::OFS_DECODE_ERR), 32'h0000_0001);
      results();
   end
endmodule
